/* gdm_params.svh */
`ifndef GDM_PARAMS_SVH
`define GDM_PARAMS_SVH
// ==========================================================================
// Register addresses
`define GDM_ADDR_ROW_DATA     8'hC0
`define GDM_ADDR_OD_ENABLE    8'hE4
`define GDM_ADDR_OD_SELECT    8'hE5
// ==========================================================================
// Field positions
`define GDM_MASK_MSB          15
`define GDM_MASK_LSB          8
`define GDM_DATA_MSB          7
`define GDM_DATA_LSB          0
`define GDM_CFG_MSB           3
`define GDM_CFG_LSB           0
// ==========================================================================
// Reset values
`define GDM_RST_ROW_DATA      16'h0000
`define GDM_RST_OD_ENABLE     4'h8
`define GDM_RST_OD_SELECT     4'h0
`endif

/* gdm_pkg.sv */
`default_nettype none
// ==========================================================================
// Types
package gdm_pkg;
  typedef struct packed {
    logic [7:0]  addr;
    logic        wr;
    logic        rd;
    logic [15:0] wdata;
  } gdm_req_t;
  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe_n;
  } gdm_pad_t;
endpackage : gdm_pkg
`default_nettype wire

/* gdm_gpio_drive.sv */
`include "gdm_params.svh"
`default_nettype none
module gdm_gpio_drive (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire gdm_pkg::gdm_req_t req,
  output var  logic [15:0]      rdata,
  input  wire logic [7:0]       row_dir_out,
  input  wire logic [7:0]       matrix_row_pin_in,
  output var  logic [7:0]       matrix_row_pin_out,
  output var  logic [7:0]       matrix_row_pin_oe_n,
  input  wire logic [3:0]       col_dir_out,
  input  wire logic [3:0]       col_data,
  output var  gdm_pkg::gdm_pad_t matrix_column_pin
);
  // ========================================================================
  // Input synchroniser
  logic [7:0] row_meta_ff;
  logic [7:0] row_sync_ff;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row_meta_ff <= 8'h00;
      row_sync_ff <= 8'h00;
    end else begin
      row_meta_ff <= matrix_row_pin_in;
      row_sync_ff <= row_meta_ff;
    end
  end
  // ========================================================================
  // Registers
  logic [15:0] row_pin_data_and_mask_ff;
  logic [3:0]  drain_only_enable_ff;
  logic [3:0]  drain_source_choice_ff;
  // One address compare serves both the write strobes and the read mux,
  // so a write and a read of the same offset can never disagree.
  function automatic logic reg_hit(input logic [7:0] addr, input logic [7:0] slot);
    return addr == slot;
  endfunction

  wire         sel_data      = reg_hit(req.addr, `GDM_ADDR_ROW_DATA);
  wire         sel_drain_en  = reg_hit(req.addr, `GDM_ADDR_OD_ENABLE);
  wire         sel_drain_sel = reg_hit(req.addr, `GDM_ADDR_OD_SELECT);
  wire         hit_data      = req.wr && sel_data;
  wire         hit_drain_en  = req.wr && sel_drain_en;
  wire         hit_drain_sel = req.wr && sel_drain_sel;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      row_pin_data_and_mask_ff <= `GDM_RST_ROW_DATA;
      drain_only_enable_ff     <= `GDM_RST_OD_ENABLE;
      drain_source_choice_ff   <= `GDM_RST_OD_SELECT;
    end else begin
      if (hit_data)
        row_pin_data_and_mask_ff <= req.wdata;
      if (hit_drain_en)
        drain_only_enable_ff <= req.wdata[`GDM_CFG_MSB:`GDM_CFG_LSB];
      if (hit_drain_sel)
        drain_source_choice_ff <= req.wdata[`GDM_CFG_MSB:`GDM_CFG_LSB];
    end
  end
  // ========================================================================
  // Read path and pin drive
  wire [7:0] row_mask = row_pin_data_and_mask_ff[`GDM_MASK_MSB:`GDM_MASK_LSB];
  wire [7:0] row_data = row_pin_data_and_mask_ff[`GDM_DATA_MSB:`GDM_DATA_LSB];
  // Input pins show the masked level, output pins their stored value.
  wire [7:0] row_view = (row_dir_out & row_data) | (~row_dir_out & row_sync_ff & row_mask);
  wire [15:0] nxt_rdata =
    sel_data      ? {row_mask, row_view} :
    sel_drain_en  ? {12'h000, drain_only_enable_ff} :
    sel_drain_sel ? {12'h000, drain_source_choice_ff} : 16'h0000;
  // A masked-off output pin floats rather than drive a stale value.
  wire [7:0] nxt_row_out  = row_data & row_mask;
  wire [7:0] nxt_row_oe_n = ~(row_dir_out & row_mask);
  // Each upper column pin has its own driver stage. An open-drain pin only
  // ever turns on the one transistor that its select bit names.
  wire [3:0] nxt_col_out;
  wire [3:0] nxt_col_oe_n;
  for (genvar g = 0; g < 4; g++) begin : g_col
    wire push_pull = !drain_only_enable_ff[g];
    wire low_only  = drain_only_enable_ff[g] && !drain_source_choice_ff[g];
    wire high_only = drain_only_enable_ff[g] && drain_source_choice_ff[g];
    assign nxt_col_out[g]  = col_data[g];
    assign nxt_col_oe_n[g] = ~(col_dir_out[g] &
                               (push_pull | (low_only & ~col_data[g]) | (high_only & col_data[g])));
  end : g_col
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata                  <= 16'h0000;
      matrix_row_pin_out     <= 8'h00;
      matrix_row_pin_oe_n    <= 8'hFF;
      matrix_column_pin.out  <= 4'h0;
      matrix_column_pin.oe_n <= 4'hF;
    end else begin
      if (req.rd)
        rdata <= nxt_rdata;
      matrix_row_pin_out     <= nxt_row_out;
      matrix_row_pin_oe_n    <= nxt_row_oe_n;
      matrix_column_pin.out  <= nxt_col_out;
      matrix_column_pin.oe_n <= nxt_col_oe_n;
    end
  end
  // ========================================================================
  // Checks
  // Every pin property samples the driver state one edge before the pin,
  // because the pads are registered and lag the configuration by a cycle.
  // Reset is left out, as the pads are forced to float there.
  // Each sequence names one driver or read state; only s_irq_pin_default, s_pin2_push_pull and s_row_read serve two properties.
  // chk_od_low_side and chk_od_high_side spell out their pin 0 state inline, so a fix to a sequence misses them.

  sequence s_pin0_low_only;
    drain_only_enable_ff[0] && !drain_source_choice_ff[0] && col_dir_out[0];
  endsequence

  sequence s_pin0_high_only;
    drain_only_enable_ff[0] && drain_source_choice_ff[0] && col_dir_out[0];
  endsequence

  sequence s_irq_pin_default;
    drain_only_enable_ff[3] && !drain_source_choice_ff[3] && col_dir_out[3];
  endsequence

  sequence s_pin2_push_pull;
    !drain_only_enable_ff[2] && col_dir_out[2];
  endsequence

  sequence s_row1_driven;
    row_dir_out[1] && row_mask[1];
  endsequence

  sequence s_row_read;
    req.rd && sel_data;
  endsequence

  // ========================================================================
  // Column pins
  // Pin 0 sees every open-drain case and pin 2 stays a full buffer.
  // The pin shared with the interrupt line is watched in its reset mode.

  chk_od_low_side: assert property (@(posedge clk) disable iff (rst)
    (drain_only_enable_ff[0] && !drain_source_choice_ff[0] && col_data[0])
    |=> matrix_column_pin.oe_n[0])
    else $error("low side drove high");

  chk_od_low_drive: assert property (@(posedge clk) disable iff (rst)
    s_pin0_low_only ##0 !col_data[0]
    |=> (!matrix_column_pin.oe_n[0] && !matrix_column_pin.out[0]))
    else $error("low side did not pull down");

  chk_od_high_side: assert property (@(posedge clk) disable iff (rst)
    (drain_only_enable_ff[0] && drain_source_choice_ff[0] && !col_data[0])
    |=> matrix_column_pin.oe_n[0])
    else $error("high side drove low");

  chk_od_high_drive: assert property (@(posedge clk) disable iff (rst)
    s_pin0_high_only ##0 col_data[0]
    |=> (!matrix_column_pin.oe_n[0] && matrix_column_pin.out[0]))
    else $error("high side did not drive up");

  chk_irq_pin_float: assert property (@(posedge clk) disable iff (rst)
    s_irq_pin_default ##0 col_data[3]
    |=> matrix_column_pin.oe_n[3])
    else $error("shared pin drove high");

  chk_irq_pin_pull: assert property (@(posedge clk) disable iff (rst)
    s_irq_pin_default ##0 !col_data[3]
    |=> (!matrix_column_pin.oe_n[3] && !matrix_column_pin.out[3]))
    else $error("shared pin did not pull down");

  chk_pp_drive: assert property (@(posedge clk) disable iff (rst)
    (!drain_only_enable_ff[1] && col_dir_out[1])
    |=> !matrix_column_pin.oe_n[1])
    else $error("push-pull not driven");

  chk_pp_high: assert property (@(posedge clk) disable iff (rst)
    s_pin2_push_pull ##0 col_data[2]
    |=> (!matrix_column_pin.oe_n[2] && matrix_column_pin.out[2]))
    else $error("push-pull high wrong");

  chk_pp_low: assert property (@(posedge clk) disable iff (rst)
    s_pin2_push_pull ##0 !col_data[2]
    |=> (!matrix_column_pin.oe_n[2] && !matrix_column_pin.out[2]))
    else $error("push-pull low wrong");

  chk_col_input: assert property (@(posedge clk) disable iff (rst)
    !col_dir_out[0]
    |=> matrix_column_pin.oe_n[0])
    else $error("input column driven");

  chk_select_ignored: assert property (@(posedge clk) disable iff (rst)
    (!drain_only_enable_ff[2] && drain_source_choice_ff[2] && col_dir_out[2])
    |=> !matrix_column_pin.oe_n[2])
    else $error("select changed a full buffer");

  chk_col_data_out: assert property (@(posedge clk) disable iff (rst)
    1'b1
    |=> matrix_column_pin.out == $past(col_data))
    else $error("column data not passed");

  // ========================================================================
  // Row pins
  // A masked pin must neither drive nor report its level.
  // Input levels are checked against the second synchroniser stage.

  chk_row_masked: assert property (@(posedge clk) disable iff (rst)
    !row_mask[0]
    |=> (matrix_row_pin_oe_n[0] && !matrix_row_pin_out[0]))
    else $error("masked row drove");

  chk_row_drive: assert property (@(posedge clk) disable iff (rst)
    s_row1_driven
    |=> (!matrix_row_pin_oe_n[1] && matrix_row_pin_out[1] == $past(row_data[1])))
    else $error("enabled row not driven");

  chk_row_input_float: assert property (@(posedge clk) disable iff (rst)
    !row_dir_out[1]
    |=> matrix_row_pin_oe_n[1])
    else $error("input row driven");

  chk_row_read: assert property (@(posedge clk) disable iff (rst)
    (req.rd && sel_data && !row_dir_out[2] && !row_mask[2])
    |=> !rdata[2])
    else $error("masked input read set");

  chk_row_read_level: assert property (@(posedge clk) disable iff (rst)
    s_row_read ##0 (!row_dir_out[2] && row_mask[2])
    |=> rdata[2] == $past(row_sync_ff[2]))
    else $error("enabled input level lost");

  chk_row_read_out: assert property (@(posedge clk) disable iff (rst)
    s_row_read ##0 row_dir_out[3]
    |=> rdata[3] == $past(row_data[3]))
    else $error("output row read wrong");

  // ========================================================================
  // Register file
  // Reserved bits are dropped on write, so they can only read back as zero.
  // Read data only moves on a read, so a slow host still sees its answer.

  chk_mask_field: assert property (@(posedge clk) disable iff (rst)
    (req.rd && sel_data)
    |=> rdata[15:8] == $past(row_mask))
    else $error("mask field wrong");

  chk_mask_write: assert property (@(posedge clk) disable iff (rst)
    hit_data
    |=> row_mask == $past(req.wdata[15:8]))
    else $error("mask not stored");

  chk_data_write: assert property (@(posedge clk) disable iff (rst)
    hit_data
    |=> row_data == $past(req.wdata[7:0]))
    else $error("data not stored");

  chk_data_hold: assert property (@(posedge clk) disable iff (rst)
    !hit_data
    |=> $stable(row_pin_data_and_mask_ff))
    else $error("data changed without write");

  chk_cfg_reserved: assert property (@(posedge clk) disable iff (rst)
    (req.rd && sel_drain_en)
    |=> rdata[15:4] == 12'h000)
    else $error("reserved bits nonzero");

  chk_sel_reserved: assert property (@(posedge clk) disable iff (rst)
    (req.rd && sel_drain_sel)
    |=> rdata[15:4] == 12'h000)
    else $error("select reserved bits nonzero");

  chk_en_write: assert property (@(posedge clk) disable iff (rst)
    hit_drain_en
    |=> drain_only_enable_ff == $past(req.wdata[3:0]))
    else $error("enable not stored");

  chk_sel_write: assert property (@(posedge clk) disable iff (rst)
    hit_drain_sel
    |=> drain_source_choice_ff == $past(req.wdata[3:0]))
    else $error("select not stored");

  chk_unmapped_read: assert property (@(posedge clk) disable iff (rst)
    (req.rd && !sel_data && !sel_drain_en && !sel_drain_sel)
    |=> rdata == 16'h0000)
    else $error("unmapped read nonzero");

  chk_rdata_hold: assert property (@(posedge clk) disable iff (rst)
    !req.rd
    |=> $stable(rdata))
    else $error("read data moved without read");

  chk_ode_reset: assert property (@(posedge clk)
    $fell(rst)
    |-> drain_only_enable_ff == 4'h8)
    else $error("enable reset wrong");

  chk_regs_reset: assert property (@(posedge clk)
    $fell(rst)
    |-> (drain_source_choice_ff == 4'h0 && row_pin_data_and_mask_ff == 16'h0000))
    else $error("register reset wrong");
endmodule // gdm_gpio_drive
`default_nettype wire

/* gdm_far_model.sv */
`default_nettype none
// ==========================================================================
// Far side of the row pins
// A floating pin settles to the pull level, so a stale value never reads back.
module gdm_far_model (
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe_n,
  input  wire logic [7:0] pull,
  output var  logic [7:0] pin_lvl
);
  timeunit 1ns;
  timeprecision 1ns;
  assign pin_lvl = (pin_out & ~pin_oe_n) | (pull & pin_oe_n);
endmodule // gdm_far_model
`default_nettype wire

/* tb_top.sv */
`default_nettype none
// ==========================================================================
// Bench
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk;
  logic              rst;
  gdm_pkg::gdm_req_t req;
  logic [15:0]       rdata;
  logic [7:0]        dir, pull, lvl, rout, roe_n;
  logic [3:0]        cdat, cdir;
  gdm_pkg::gdm_pad_t col;
  int                err_total;
  int                checks;
  gdm_gpio_drive dut (.clk(clk), .rst(rst), .req(req), .rdata(rdata), .row_dir_out(dir),
    .matrix_row_pin_in(lvl), .matrix_row_pin_out(rout), .matrix_row_pin_oe_n(roe_n),
    .col_dir_out(cdir), .col_data(cdat), .matrix_column_pin(col));
  gdm_far_model far (.pin_out(rout), .pin_oe_n(roe_n), .pull(pull), .pin_lvl(lvl));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // Two falling edges per access, so pins have taken their one-cycle lag.
  task automatic acc(input logic [7:0] a, input logic w, input logic [15:0] d);
    req = '{a, w, ~w, d};
    @(negedge clk);
    req = '0;
    @(negedge clk);
  endtask
  task automatic finish_test;
    if (err_total == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic t_reset;
    acc(8'hE4, 1'b0, 16'h0);
    chk(rdata, 16'h0008);
    acc(8'hE5, 1'b0, 16'h0);
    chk(rdata, 16'h0000);
    acc(8'hC0, 1'b0, 16'h0);
    chk(rdata, 16'h0000);
  endtask
  task automatic t_cfg;
    acc(8'hE4, 1'b1, 16'hFFFF);
    acc(8'hE4, 1'b0, 16'h0);
    chk(rdata, 16'h000F);
    acc(8'hE5, 1'b1, 16'hFFFA);
    acc(8'hE5, 1'b0, 16'h0);
    chk(rdata, 16'h000A);
    acc(8'h55, 1'b0, 16'h0);
    chk(rdata, 16'h0000);
  endtask
  task automatic t_col;
    logic [3:0] e, s, drv;
    for (int i = 0; i < 8; i++) begin
      e = i[0] ? 4'h9 : 4'h0;
      s = i[1] ? 4'h3 : 4'h0;
      cdat = i[2] ? 4'hA : 4'h5;
      cdir = i[2] ? 4'h7 : 4'hF;
      drv = cdir & (~e | (~s & ~cdat) | (s & cdat));
      acc(8'hE4, 1'b1, {12'h0, e});
      acc(8'hE5, 1'b1, {12'h0, s});
      chk({8'h00, col.oe_n, col.out & drv}, {8'h00, ~drv, cdat & drv});
    end
  endtask
  task automatic t_row;
    dir = 8'hFF;
    acc(8'hC0, 1'b1, 16'h0F5A);
    chk({roe_n, rout & ~roe_n}, 16'hF00A);
    acc(8'hC0, 1'b0, 16'h0);
    chk(rdata, 16'h0F5A);
    dir = 8'h00;
    pull = 8'h96;
    acc(8'hC0, 1'b1, 16'h3CFF);
    repeat (3) @(negedge clk);
    acc(8'hC0, 1'b0, 16'h0);
    chk(rdata, 16'h3C14);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    finish_test();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    dir = 8'h00;
    pull = 8'hFF;
    cdat = 4'h5;
    cdir = 4'hF;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    t_reset();
    t_cfg();
    t_col();
    t_row();
    finish_test();
  end
endmodule // tb_top
`default_nettype wire
